// file: common/tbgp_defs.svh
`ifndef TBGP_DEFS_SVH
`define TBGP_DEFS_SVH

// ************************************************************
// register map (byte addresses, one aligned word each)
// ************************************************************
`define TBGP_THREE_DATA_IDX   8'h0a
`define TBGP_TWO_DATA_IDX     8'h0b
`define TBGP_THREE_DIR_IDX    8'h0c
`define TBGP_TWO_DIR_IDX      8'h0d
`define TBGP_KEY_EN_IDX       8'h0e
`define TBGP_THREE_DATA_ADDR  12'h028
`define TBGP_TWO_DATA_ADDR    12'h02c
`define TBGP_THREE_DIR_ADDR   12'h030
`define TBGP_TWO_DIR_ADDR     12'h034
`define TBGP_KEY_EN_ADDR      12'h038

// ************************************************************
// field layout and reset values
// ************************************************************
`define TBGP_THREE_W          3
`define TBGP_TWO_W            2
`define TBGP_KEY_W            5
`define TBGP_KEY_TWO_LSB      3
`define TBGP_DIR_RST3         3'h0
`define TBGP_DIR_RST2         2'h0
`define TBGP_KEY_RST          5'h00

`endif

// file: common/tbgp_pkg.sv
package tbgp_pkg;

	// apb request as seen by the slave
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} tbgp_apb_req_t;

	// one group of pins: output value and output enable
	typedef struct packed {
		logic [4:0] pin_out;
		logic [4:0] pin_oe;
	} tbgp_pin_drv_t;

endpackage : tbgp_pkg

// file: hw/tbgp_top.sv
// Behaviour
// R1: the first port has exactly three pins, shared with the key interrupt block.
// R2: the second port has exactly two pins, shared with the key interrupt block.
// R3: first-port data latch bits are read/write and untouched by reset.
// R4: second-port data latch bits likewise keep their values through reset.
// R5: a set key enable on a first-port pin makes it an input, overriding direction.
// R6: key enable bits 4 and 3 make the second-port pins interrupt inputs.
// R7: a set key enable on a second-port pin overrides its direction bit.
// R8: first-port direction one drives the pin, zero leaves it high impedance.
// R9: second-port direction one drives the pin, zero makes it an input.
// R10: reset clears all three first-port direction bits.
// R11: reset clears both second-port direction bits.
// R12: first-port data read gives latch where direction is one, pin otherwise.
// R13: second-port data read gives latch for outputs, pin level for inputs; code selects on the direction bit only, ignoring key enable.
// R14: data latch writes are always accepted, whatever the direction.
// R15: writing an input pin's latch stores it but leaves the sensed input alone.
// R16: direction bits read back the last value written.
// R17: software loads a first-port latch before setting direction from 0 to 1.
// R18: software loads a second-port latch before setting direction from 0 to 1.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "tbgp_defs.svh"

module tbgp_top
	import tbgp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  three_pin_in,
	output logic      [2:0]  three_pin_out,
	output logic      [2:0]  three_pin_oe,
	input  wire logic [1:0]  two_pin_in,
	output logic      [1:0]  two_pin_out,
	output logic      [1:0]  two_pin_oe,
	output logic      [4:0]  key_pin_level
);

	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] rst_sync_q;
	logic       rst_n;

	// two-stage release of the asynchronous reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ************************************************************
	// pin input synchronisers
	// ************************************************************
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	logic [4:0] pin_s3_q;
	logic [4:0] pin_level_q;

	// three stages; the level only moves once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q    <= 5'h00;
			pin_s2_q    <= 5'h00;
			pin_s3_q    <= 5'h00;
			pin_level_q <= 5'h00;
		end else if (clk_en) begin
			pin_s1_q <= {two_pin_in, three_pin_in}; // [R1] [R2]
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (int i = 0; i < 5; i++) begin
				if (pin_s2_q[i] == pin_s3_q[i]) begin
					pin_level_q[i] <= pin_s3_q[i];
				end
			end
		end
	end

	// ************************************************************
	// register decode
	// ************************************************************
	tbgp_apb_req_t req;
	logic          wr_en;
	logic          rd_en;
	logic          hit;

	assign req   = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
		pwdata: pwdata};
	assign hit   = (req.paddr == `TBGP_THREE_DATA_ADDR) || (req.paddr == `TBGP_TWO_DATA_ADDR)
		|| (req.paddr == `TBGP_THREE_DIR_ADDR) || (req.paddr == `TBGP_TWO_DIR_ADDR)
		|| (req.paddr == `TBGP_KEY_EN_ADDR);
	// read data is prepared in setup; a write lands only at the access edge with pready high
	assign wr_en = clk_en && req.psel && req.penable && pready && req.pwrite && hit;
	assign rd_en = clk_en && req.psel && !req.penable && !req.pwrite;

	// ************************************************************
	// data latches (no reset)
	// ************************************************************
	logic [2:0] three_pin_data_latch_q;
	logic [1:0] two_pin_data_latch_q;

	// latches take writes whatever the direction, and have no reset
	always_ff @(posedge clk) begin
		if (wr_en && req.paddr == `TBGP_THREE_DATA_ADDR) begin
			three_pin_data_latch_q <= req.pwdata[2:0]; // [R3] [R14] [R15]
		end
		if (wr_en && req.paddr == `TBGP_TWO_DATA_ADDR) begin
			two_pin_data_latch_q <= req.pwdata[1:0]; // [R4] [R14] [R15]
		end
	end

	// ************************************************************
	// direction and key enable registers
	// ************************************************************
	logic [2:0] three_pin_direction_q;
	logic [1:0] two_pin_direction_q;
	logic [4:0] key_interrupt_pin_enable_q;

	// direction bits start as inputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			three_pin_direction_q <= `TBGP_DIR_RST3; // [R10]
			two_pin_direction_q   <= `TBGP_DIR_RST2; // [R11]
		end else if (wr_en) begin
			if (req.paddr == `TBGP_THREE_DIR_ADDR) begin
				three_pin_direction_q <= req.pwdata[2:0]; // [R16]
			end
			if (req.paddr == `TBGP_TWO_DIR_ADDR) begin
				two_pin_direction_q <= req.pwdata[1:0]; // [R16]
			end
		end
	end

	// key enables stand in for the key interrupt block's control bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			key_interrupt_pin_enable_q <= `TBGP_KEY_RST;
		end else if (wr_en && req.paddr == `TBGP_KEY_EN_ADDR) begin
			key_interrupt_pin_enable_q <= req.pwdata[4:0];
		end
	end

	// ************************************************************
	// pin drive
	// ************************************************************
	logic [2:0] three_drive;
	logic [1:0] two_drive;

	// a set key enable forces the pin to input
	assign three_drive = three_pin_direction_q
		& ~key_interrupt_pin_enable_q[2:0]; // [R5] [R8]
	assign two_drive   = two_pin_direction_q
		& ~key_interrupt_pin_enable_q[`TBGP_KEY_W-1:`TBGP_KEY_TWO_LSB]; // [R6] [R7] [R9]

	// registered pin outputs and level to the key interrupt block
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			three_pin_out <= 3'h0;
			three_pin_oe  <= 3'h0;
			two_pin_out   <= 2'h0;
			two_pin_oe    <= 2'h0;
			key_pin_level <= 5'h00;
		end else if (clk_en) begin
			three_pin_out <= three_pin_data_latch_q;
			three_pin_oe  <= three_drive;            // [R8]
			two_pin_out   <= two_pin_data_latch_q;
			two_pin_oe    <= two_drive;              // [R9]
			key_pin_level <= pin_level_q;            // [R15]
		end
	end

	// ************************************************************
	// read path and apb answer
	// ************************************************************
	logic [31:0] rd_d;

	// data reads mix latch and pin per direction bit
	always_comb begin
		rd_d = 32'h0000_0000;
		case (req.paddr)
			`TBGP_THREE_DATA_ADDR: rd_d[2:0] = (three_pin_direction_q & three_pin_data_latch_q)
				| (~three_pin_direction_q & pin_level_q[2:0]); // [R12]
			`TBGP_TWO_DATA_ADDR:   rd_d[1:0] = (two_pin_direction_q & two_pin_data_latch_q)
				| (~two_pin_direction_q & pin_level_q[4:3]); // [R13]
			`TBGP_THREE_DIR_ADDR:  rd_d[2:0] = three_pin_direction_q; // [R16]
			`TBGP_TWO_DIR_ADDR:    rd_d[1:0] = two_pin_direction_q;   // [R16]
			`TBGP_KEY_EN_ADDR:     rd_d[4:0] = key_interrupt_pin_enable_q;
			default:               rd_d      = 32'h0000_0000;
		endcase
	end

	// no wait state: answer in the first access cycle, error on unmapped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= req.psel && !req.penable;
			pslverr <= req.psel && !req.penable && !hit;
			if (rd_en) begin
				prdata <= rd_d;
			end
		end
	end

endmodule : tbgp_top

// file: sim/tbgp_pad_model.sv
`timescale 1ns/1ns
// ****
// board pads
// ****
module tbgp_pad_model (
	input  wire logic [4:0] out,
	input  wire logic [4:0] oe,
	input  wire logic [4:0] board,
	output logic      [4:0] pin
);
	// an enabled buffer owns its pad, a released pad shows the board level
	assign pin = (oe & out) | (~oe & board);
endmodule : tbgp_pad_model

// file: sim/tbgp_top_asserts.sv
`timescale 1ns/1ns
// ****
// bus and pin checks
// ****
module tbgp_top_asserts (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [2:0]  three_pin_out,
	input wire logic [2:0]  three_pin_oe,
	input wire logic [1:0]  two_pin_out,
	input wire logic [1:0]  two_pin_oe
);
	logic       setup;
	logic       wr;
	logic       mapped;
	logic [4:0] oe;
	// setup phase, write setup, decoded address, joined enables
	assign setup  = psel && !penable;
	assign wr     = setup && pwrite;
	assign mapped = paddr inside {12'h028, 12'h02c, 12'h030, 12'h034, 12'h038};
	assign oe     = {two_pin_oe, three_pin_oe};
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_ready_pulse: assert property (setup |=> pready ##1 !pready)
		else $error("ready not a single pulse");
	a_ready_cause: assert property (pready |-> $past(setup))
		else $error("ready without setup");
	a_err_unmapped: assert property (setup && !mapped |=> pslverr)
		else $error("no error on unmapped");
	a_three_out: assert property (wr && paddr == 12'h028
		|-> ##3 three_pin_out == $past(pwdata[2:0], 3)) else $error("latch not driven");
	a_two_out: assert property (wr && paddr == 12'h02c
		|-> ##3 two_pin_out == $past(pwdata[1:0], 3)) else $error("latch not driven");
	a_key_override: assert property (wr && paddr == 12'h038 && pwdata[4:0] == 5'h1f
		|-> ##3 oe == 5'h00) else $error("key enable left a buffer on");
	a_reset_oe: assert property ($rose(rstn) |-> oe == 5'h00)
		else $error("buffer on out of reset");
	a_oe_cause: assert property (!$stable(oe) |-> $past(wr, 3))
		else $error("buffer moved without write");
endmodule : tbgp_top_asserts

bind tbgp_top tbgp_top_asserts tbgp_top_asserts_inst (.clk, .rstn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .three_pin_out, .three_pin_oe, .two_pin_out, .two_pin_oe);

// file: sim/testbench.sv
`timescale 1ns/1ns
// ****
// gpio port bench
// ****
module testbench;
	typedef struct packed {logic [4:0] dir, lat, brd, key, rd, oe, lvl;} tbgp_row_t;
	logic        clk = 1'h0;
	logic        rstn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [4:0]  board = 5'h00;
	logic        clk_en = 1'h1;
	logic [31:0] rd;
	logic        err_seen;
	wire  [31:0] prdata;
	wire         pready, pslverr;
	wire  [2:0]  three_pin_in, three_pin_out, three_pin_oe;
	wire  [1:0]  two_pin_in, two_pin_out, two_pin_oe;
	wire  [4:0]  key_pin_level;
	int          err_total = 0;
	int          n_compared = 0;
	// direction, latch, board, key enable, then read, enable and level expected
	tbgp_row_t   rows [4] = '{'{5'h00, 5'h1f, 5'h0a, 5'h00, 5'h0a, 5'h00, 5'h0a},
		'{5'h1f, 5'h15, 5'h0a, 5'h00, 5'h15, 5'h1f, 5'h15},
		'{5'h1f, 5'h0a, 5'h15, 5'h19, 5'h0a, 5'h06, 5'h13},
		'{5'h0c, 5'h03, 5'h1f, 5'h00, 5'h13, 5'h0c, 5'h13}};
	// device and its pads
	tbgp_top tbgp_top_inst (.clk, .rstn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .three_pin_in, .three_pin_out, .three_pin_oe, .two_pin_in,
		.two_pin_out, .two_pin_oe, .key_pin_level);
	tbgp_pad_model tbgp_pad_model_inst (.out({two_pin_out, three_pin_out}),
		.oe({two_pin_oe, three_pin_oe}), .board, .pin({two_pin_in, three_pin_in}));
	always #2 clk = ~clk;
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one apb transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		err_seen = pslverr;
		if (n >= 50) begin
			err_total++;
			$display("ERROR pready expected 1 seen 0");
			final_report();
		end
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'h1;
		repeat (3) @(posedge clk);
		chk("oe", 32'h0, {27'h0, two_pin_oe, three_pin_oe});
		apb(1'h0, 12'h030, 32'h0);
		chk("dir3", 32'h0, rd);
		apb(1'h0, 12'h034, 32'h0);
		chk("dir2", 32'h0, rd);
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1'h1, 12'h028, {27'h0, rows[i].lat});
			apb(1'h1, 12'h02c, {27'h0, rows[i].lat >> 3});
			apb(1'h1, 12'h038, {27'h0, rows[i].key});
			apb(1'h1, 12'h030, {27'h0, rows[i].dir});
			apb(1'h1, 12'h034, {27'h0, rows[i].dir >> 3});
			board <= rows[i].brd;
			repeat (8) @(posedge clk);
			apb(1'h0, 12'h028, 32'h0);
			chk("data3", {29'h0, rows[i].rd[2:0]}, rd);
			apb(1'h0, 12'h02c, 32'h0);
			chk("data2", {30'h0, rows[i].rd[4:3]}, rd);
			apb(1'h0, 12'h030, 32'h0);
			chk("dir3", {29'h0, rows[i].dir[2:0]}, rd);
			apb(1'h0, 12'h034, 32'h0);
			chk("dir2", {30'h0, rows[i].dir[4:3]}, rd);
			chk("pins", {17'h0, rows[i].oe, rows[i].lat, rows[i].lvl}, {17'h0, two_pin_oe, three_pin_oe, two_pin_out, three_pin_out, key_pin_level});
			$display("row %0d done", i);
		end
		apb(1'h1, 12'h03c, 32'h1f);
		chk("wr err", 32'h1, {31'h0, err_seen});
		apb(1'h0, 12'h03c, 32'h0);
		chk("rd unmapped", 32'h0, rd);
		$display("unmapped test done");
		// clock enable low freezes the pin level path
		board <= 5'h00;
		repeat (8) @(posedge clk);
		clk_en <= 1'h0;
		board  <= 5'h1f;
		repeat (8) @(posedge clk);
		chk("frozen lvl", 32'h0, {27'h0, key_pin_level});
		clk_en <= 1'h1;
		repeat (8) @(posedge clk);
		chk("thawed lvl", 32'h13, {27'h0, key_pin_level});
		$display("clock enable test done");
		rstn <= 1'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'h1;
		repeat (3) @(posedge clk);
		chk("oe", 32'h0, {27'h0, two_pin_oe, three_pin_oe});
		apb(1'h1, 12'h030, 32'h7);
		apb(1'h1, 12'h034, 32'h3);
		apb(1'h0, 12'h028, 32'h0);
		chk("kept3", 32'h3, rd);
		apb(1'h0, 12'h02c, 32'h0);
		chk("kept2", 32'h0, rd);
		$display("second reset test done");
		final_report();
	end
endmodule : testbench
